// ---- logic/ccsc_regs.svh ----
// Constants for the processor clock stop control
`ifndef CCSC_REGS_SVH
`define CCSC_REGS_SVH
`define CCSC_CLK_PERIOD_NS 100
`define CCSC_STABLE_TIME_US 1500
`define CCSC_STABLE_CYCLES ((`CCSC_STABLE_TIME_US * 1000) / `CCSC_CLK_PERIOD_NS)
`define CCSC_HALT_SAMPLES 2
`define CCSC_RESTART_MAX_CYCLES 2
`define CCSC_DIV_W 4
`define CCSC_DIV_HALF 4'h2
`define CCSC_MODE_DIFF 1'b1
`define CCSC_MODE_OD 1'b0
`endif

// ---- logic/ccsc_pkg.sv ----
// Types for the processor clock stop control
package ccsc_pkg;
  typedef enum logic [1:0] {
    CCSC_WARMUP,
    CCSC_RUN,
    CCSC_PARK
  } ccsc_state_t;
endpackage : ccsc_pkg

// ---- logic/ccsc_sync.sv ----
// Two-stage level synchroniser
module ccsc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Level
  input wire logic din,
  output logic dout
);
  logic stage1;
  logic next_stage1;
  logic next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule : ccsc_sync

// ---- logic/ccsc_top.sv ----
// Processor clock stop control top
`include "ccsc_regs.svh"
module ccsc_top #(
  parameter int STABLE_CYCLES = `CCSC_STABLE_CYCLES,
  parameter int DIV_W = `CCSC_DIV_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control pins
  input wire logic proc_clock_halt_n,
  input wire logic processor_type_select,
  // True leg
  output logic proc_clk_true_leg,
  output logic proc_clk_true_leg_oe,
  // Complementary leg
  output logic proc_clk_comp_leg,
  output logic proc_clk_comp_leg_oe,
  // Status
  output logic clocks_stable,
  output logic clocks_halted
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic halt_n_s;
  logic type_s;

  ccsc_sync #(.RESET_VAL(1'b1)) u_sync_halt (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(proc_clock_halt_n),
    .dout(halt_n_s)
  );

  ccsc_sync #(.RESET_VAL(1'b1)) u_sync_type (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(processor_type_select),
    .dout(type_s)
  );

  // ------------------------------------------------------------
  // Processor clock generation
  // ------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic clk_phase;
  logic next_clk_phase;
  logic run_en;
  logic fall_evt;
  logic comp_rise;

  always_comb begin
    next_div_cnt = div_cnt;
    next_clk_phase = clk_phase;
    fall_evt = 1'b0;
    if (!run_en) begin
      next_div_cnt = '0;
      next_clk_phase = 1'b1;
    end else if (div_cnt == DIV_W'(`CCSC_DIV_HALF - 4'h1)) begin
      next_div_cnt = '0;
      next_clk_phase = ~clk_phase;
      fall_evt = clk_phase;
    end else begin
      next_div_cnt = div_cnt + DIV_W'(1);
    end
  end

  assign comp_rise = fall_evt;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= '0;
      clk_phase <= 1'b1;
    end else begin
      div_cnt <= next_div_cnt;
      clk_phase <= next_clk_phase;
    end
  end

  // ------------------------------------------------------------
  // Power-up stabilisation window
  // ------------------------------------------------------------
  logic [31:0] warm_cnt;
  logic [31:0] next_warm_cnt;
  logic warm_done;

  // Counter holds at its end value, so it never wraps
  assign warm_done = (warm_cnt >= 32'(STABLE_CYCLES - 1));

  always_comb begin
    next_warm_cnt = warm_cnt;
    if (!warm_done) begin
      next_warm_cnt = warm_cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      warm_cnt <= 32'h0;
    end else begin
      warm_cnt <= next_warm_cnt;
    end
  end

  // ------------------------------------------------------------
  // Stop control state machine
  // ------------------------------------------------------------
  ccsc_pkg::ccsc_state_t state;
  ccsc_pkg::ccsc_state_t next_state;
  logic [1:0] low_samples;
  logic [1:0] next_low_samples;

  always_comb begin
    next_state = state;
    next_low_samples = low_samples;
    case (state)
      ccsc_pkg::CCSC_WARMUP: begin
        if (warm_done) begin
          next_state = ccsc_pkg::CCSC_RUN;
        end
      end
      ccsc_pkg::CCSC_RUN: begin
        if (halt_n_s) begin
          next_low_samples = 2'h0;
        end else if (comp_rise) begin
          // Same sampling whatever the output style
          if (low_samples == 2'(`CCSC_HALT_SAMPLES - 1)) begin
            next_state = ccsc_pkg::CCSC_PARK;
            next_low_samples = 2'h0;
          end else begin
            next_low_samples = low_samples + 2'h1;
          end
        end
      end
      ccsc_pkg::CCSC_PARK: begin
        if (halt_n_s) begin
          next_state = ccsc_pkg::CCSC_RUN;
        end
      end
      default: begin
        next_state = ccsc_pkg::CCSC_WARMUP;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ccsc_pkg::CCSC_WARMUP;
      low_samples <= 2'h0;
    end else begin
      state <= next_state;
      low_samples <= next_low_samples;
    end
  end

  // Stop falls at comp rise, so true leg is already high when parked
  // Restart begins with a full high phase from counter zero
  assign run_en = (state != ccsc_pkg::CCSC_PARK);

  // ------------------------------------------------------------
  // Output drivers
  // ------------------------------------------------------------
  logic next_true;
  logic next_true_oe;
  logic next_comp;
  logic next_comp_oe;

  always_comb begin
    if (next_state == ccsc_pkg::CCSC_PARK) begin
      next_true = 1'b1;
      next_true_oe = 1'b1;
      next_comp = 1'b0;
      next_comp_oe = 1'b0;
    end else if (type_s == `CCSC_MODE_DIFF) begin
      next_true = next_clk_phase;
      next_true_oe = 1'b1;
      next_comp = ~next_clk_phase;
      next_comp_oe = 1'b1;
    end else begin
      next_true = 1'b0;
      next_true_oe = ~next_clk_phase;
      next_comp = 1'b0;
      next_comp_oe = next_clk_phase;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      proc_clk_true_leg <= 1'b1;
      proc_clk_true_leg_oe <= 1'b1;
      proc_clk_comp_leg <= 1'b0;
      proc_clk_comp_leg_oe <= 1'b1;
    end else begin
      proc_clk_true_leg <= next_true;
      proc_clk_true_leg_oe <= next_true_oe;
      proc_clk_comp_leg <= next_comp;
      proc_clk_comp_leg_oe <= next_comp_oe;
    end
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  logic next_stable;
  logic next_halted;

  // Flags move on the same edge as the state they report
  always_comb begin
    next_stable = (next_state != ccsc_pkg::CCSC_WARMUP);
    next_halted = (next_state == ccsc_pkg::CCSC_PARK);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      clocks_stable <= 1'b0;
      clocks_halted <= 1'b0;
    end else begin
      clocks_stable <= next_stable;
      clocks_halted <= next_halted;
    end
  end
endmodule : ccsc_top

// ---- testbench/ccsc_assertions.sv ----
// Checker for the processor clock stop control
module ccsc_assertions #(
  parameter int STABLE_CYCLES = 20
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control pins
  input wire logic proc_clock_halt_n,
  input wire logic processor_type_select,
  // Leg outputs
  input wire logic proc_clk_true_leg,
  input wire logic proc_clk_true_leg_oe,
  input wire logic proc_clk_comp_leg,
  input wire logic proc_clk_comp_leg_oe,
  // Status
  input wire logic clocks_stable,
  input wire logic clocks_halted
);
  logic tw;
  logic [3:0] low_cnt, next_low_cnt;
  int cyc, next_cyc;
  assign tw = proc_clk_true_leg | !proc_clk_true_leg_oe;
  always_comb begin
    next_low_cnt = low_cnt + {3'h0, low_cnt != 4'hF};
    if (proc_clock_halt_n || !clocks_stable) next_low_cnt = 4'h0;
    next_cyc = cyc + int'(cyc <= STABLE_CYCLES + 1);
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt <= 4'h0;
      cyc <= 0;
    end else begin
      low_cnt <= next_low_cnt;
      cyc <= next_cyc;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence seq_resume;
    tw [*2] ##1 !tw [*2];
  endsequence
  a_park_levels: assert property (clocks_halted |-> proc_clk_true_leg &&
    proc_clk_true_leg_oe && !proc_clk_comp_leg && !proc_clk_comp_leg_oe) else $error("park");
  a_halt_two_edges: assert property ($rose(clocks_halted) |-> low_cnt >= 4'h5)
    else $error("early halt");
  a_halt_bound: assert property (low_cnt == 4'hE |-> clocks_halted)
    else $error("late halt");
  a_restart_time: assert property ($rose(proc_clock_halt_n) && clocks_halted |->
    ##[1:8] !clocks_halted) else $error("late restart");
  a_resume_shape: assert property ($fell(clocks_halted) |-> seq_resume)
    else $error("bad resume pulse");
  a_diff_pair: assert property (clocks_stable && !clocks_halted && processor_type_select |->
    proc_clk_true_leg_oe && proc_clk_comp_leg_oe && proc_clk_comp_leg != proc_clk_true_leg)
    else $error("diff pair");
  a_od_pair: assert property (clocks_stable && !clocks_halted && !processor_type_select |->
    !proc_clk_true_leg && !proc_clk_comp_leg && proc_clk_true_leg_oe != proc_clk_comp_leg_oe)
    else $error("od pair");
  a_warmup_len: assert property (!clocks_stable |-> !clocks_halted &&
    cyc < STABLE_CYCLES) else $error("warmup");
endmodule : ccsc_assertions
bind ccsc_top ccsc_assertions #(.STABLE_CYCLES(STABLE_CYCLES)) ccsc_assertions_inst (
  .mclk(mclk), .sys_rst(sys_rst), .proc_clock_halt_n(proc_clock_halt_n),
  .processor_type_select(processor_type_select), .proc_clk_true_leg(proc_clk_true_leg),
  .proc_clk_true_leg_oe(proc_clk_true_leg_oe), .proc_clk_comp_leg(proc_clk_comp_leg),
  .proc_clk_comp_leg_oe(proc_clk_comp_leg_oe), .clocks_stable(clocks_stable),
  .clocks_halted(clocks_halted));

// ---- testbench/ccsc_halt_src.sv ----
// Stop request source, prompt or slow
module ccsc_halt_src (
  // Clock
  input wire logic mclk,
  // Scenario controls
  input wire logic stop_req,
  input wire logic slow,
  // Stop pin
  output logic proc_clock_halt_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] dl = 3'h0;
  initial proc_clock_halt_n = 1'b1;
  always @(posedge mclk) begin
    dl <= {dl[1:0], stop_req};
    proc_clock_halt_n <= !(slow ? dl[2] : stop_req);
  end
endmodule : ccsc_halt_src

// ---- testbench/ccsc_top_tb.sv ----
// Testbench for the processor clock stop control
module ccsc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STABLE = 20;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic sel = 1'b1;
  logic req = 1'b0;
  logic slow = 1'b0;
  logic halt_n, t, t_oe, c, c_oe, stable, halted, tw;
  int num_errors = 0;
  int n_checks = 0;
  assign tw = t | !t_oe;
  ccsc_top #(.STABLE_CYCLES(STABLE)) ccsc_top_inst (.mclk(mclk), .sys_rst(sys_rst),
    .proc_clock_halt_n(halt_n), .processor_type_select(sel), .proc_clk_true_leg(t),
    .proc_clk_true_leg_oe(t_oe), .proc_clk_comp_leg(c), .proc_clk_comp_leg_oe(c_oe),
    .clocks_stable(stable), .clocks_halted(halted));
  ccsc_halt_src ccsc_halt_src_inst (.mclk(mclk), .stop_req(req), .slow(slow),
    .proc_clock_halt_n(halt_n));
  initial begin
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic test_warmup(input logic mode, input logic s);
    @(posedge mclk);
    sys_rst <= 1'b1;
    sel <= mode;
    slow <= s;
    req <= 1'b1;
    tick(9);
    @(posedge mclk);
    sys_rst <= 1'b0;
    tick(STABLE / 2);
    chk({2'h0, stable, halted}, 4'h0);
    @(posedge mclk);
    req <= 1'b0;
    tick(STABLE / 2 + 6);
    chk({2'h0, stable, halted}, 4'h2);
  endtask : test_warmup
  task automatic test_short;
    logic seen_halt;
    seen_halt = 1'b0;
    @(posedge mclk);
    req <= 1'b1;
    tick(3);
    @(posedge mclk);
    req <= 1'b0;
    repeat (14) begin
      tick(1);
      seen_halt = seen_halt | halted;
    end
    chk({3'h0, seen_halt}, 4'h0);
  endtask : test_short
  task automatic test_halt;
    int n;
    @(posedge mclk);
    req <= 1'b1;
    for (n = 0; n < 30 && halted !== 1'b1; n++) tick(1);
    chk({3'h0, n >= (slow ? 11 : 8) && n <= (slow ? 14 : 11)}, 4'h1);
    chk({t, t_oe, c, c_oe}, 4'hC);
    @(posedge mclk);
    req <= 1'b0;
    for (n = 0; n < 30 && halted !== 1'b0; n++) tick(1);
    chk({3'h0, n <= (slow ? 12 : 9)}, 4'h1);
    for (n = 0; n < 4; n++) begin
      chk({3'h0, tw}, {3'h0, n < 2});
      tick(1);
    end
  endtask : test_halt
  initial begin
    for (int m = 0; m < 4; m++) begin
      test_warmup(m[1], m[0]);
      test_short();
      test_halt();
      test_halt();
    end
    finish_test();
  end
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule : ccsc_top_tb
